// [design/tsc_pkg.sv]
package tsc_pkg;
	localparam int SLOT_BITS = 64;
	localparam int SAMPLE_BITS = 24;
	localparam int HDR_LSB = 32;
	localparam int DATA_LSB = 24;
	localparam logic [7:0] HDR_IDLE = 8'h00;
	localparam logic [7:0] HDR_START_WR = 8'h04;
	localparam logic [7:0] HDR_START_RD = 8'h05;
	localparam logic [7:0] HDR_STOP = 8'h02;
	localparam int HB_RW = 0;
	localparam int HB_STOP = 1;
	localparam int HB_START = 2;
	localparam int REG_COUNT = 16;
	localparam logic [7:0] REG_TOP = 8'h0f;
	localparam logic [7:0] REG_SNS_POS = 8'h01;
	localparam logic [7:0] REG_PORT_LO = 8'h02;
	localparam logic [7:0] REG_PORT_HI = 8'h04;
	localparam logic [7:0] REG_POWER = 8'h00;
	localparam logic [7:0] REG_LIMIT = 8'h05;
	localparam logic [7:0] REG_FORMAT = 8'h02;
	localparam logic [7:0] REG_TDM = 8'h03;
	localparam int POWER_SOFT_POWER_DOWN_BIT = 0;
	localparam int LIMIT_EN_LSB = 0;
	localparam int FMT_AUTO_BIT = 0;
	localparam int FMT_SDATA_BIT = 1;
	localparam int FMT_PDM_BIT = 2;
	localparam int TDM_WIDTH_LSB = 0;
	localparam logic [1:0] TDM_WIDTH_64 = 2'b10;
	localparam logic [7:0] RESET_VALUE = 8'h01;
	localparam logic [7:0] DAC_SLOT = 8'h00;
	typedef enum logic [1:0] {ST_IDLE, ST_SUB, ST_DATA} tsc_seq_type;
endpackage : tsc_pkg

// [design/tsc_link_if.sv]
`timescale 1ns/1ps
// TDM link: bit clock, frame sync, host-to-device and device-to-host data.
interface tsc_link_if;
	logic bclk;
	logic fsync;
	logic sdin;
	logic sdout;
	modport host (output bclk, output fsync, output sdin, input sdout);
	modport dev (input bclk, input fsync, input sdin, output sdout);
endinterface : tsc_link_if

// [design/tsc_device.sv]
`timescale 1ns/1ps
module tsc_device
	import tsc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	tsc_link_if.dev link,
	input wire logic i_standalone,
	input wire logic i_tdm_mode,
	input wire logic [1:0] i_ctl_pins,
	output logic [23:0] o_sample,
	output logic o_sample_stb,
	output logic [7:0] o_regs_flat [REG_COUNT],
	output logic [1:0] o_sa_slot,
	output logic o_boost_down,
	output logic o_shutdown
);
	// Link-side logic runs on the bit clock; reset is brought over first.
	logic rst_s1_q, rst_s2_q;
	always_ff @(posedge link.bclk) begin
		rst_s1_q <= i_rst_n;
		rst_s2_q <= rst_s1_q;
	end

	logic [5:0] bit_d, bit_q;
	logic [63:0] sh_d, sh_q;
	logic [7:0] tx_d, tx_q;
	logic [7:0] out_d, out_q;
	tsc_seq_type st_d, st_q;
	logic rd_d, rd_q;
	logic [7:0] sub_d, sub_q;
	logic [7:0] regs_d [REG_COUNT];
	logic [7:0] regs_q [REG_COUNT];
	logic [23:0] smp_d, smp_q;
	logic tog_d, tog_q;
	logic [63:0] word;
	logic [7:0] hdr, dat;
	logic [5:0] tx_at;

	// Subaddresses above the top register all map onto the top register.
	function automatic logic [3:0] reg_ix(input logic [7:0] a);
		return (a > REG_TOP) ? REG_TOP[3:0] : a[3:0];
	endfunction : reg_ix

	// Slot group counter aligned by frame sync; a whole group ends at bit 63.
	always_comb begin
		word = {sh_q[62:0], link.sdin};
		hdr = word[HDR_LSB +: 8];
		dat = word[DATA_LSB +: 8];
		bit_d = link.fsync ? 6'h01 : bit_q + 6'h01;
		sh_d = word;
		tx_d = tx_q;
		out_d = out_q;
		st_d = st_q;
		rd_d = rd_q;
		sub_d = sub_q;
		regs_d = regs_q;
		smp_d = smp_q;
		tog_d = tog_q;
		if (bit_q == 6'h3f) begin
			smp_d = word[63 -: SAMPLE_BITS];
			tog_d = ~tog_q;
			out_d = 8'h00;
			if (hdr[HB_START]) begin
				st_d = ST_SUB;
				rd_d = hdr[HB_RW];
				sub_d = dat;
			end else if (hdr[HB_STOP]) begin
				st_d = ST_IDLE;
			end else begin
				case (st_q)
					ST_SUB, ST_DATA: begin
						st_d = ST_DATA;
						if (rd_q && st_q == ST_SUB) begin
							// The first read frame answers with the addressed register.
							out_d = regs_q[reg_ix(sub_q)];
						end else if (rd_q) begin
							// Past the top the last register keeps repeating.
							sub_d = (sub_q >= REG_TOP) ? REG_TOP : sub_q + 8'h01;
							out_d = regs_q[reg_ix(sub_d)];
						end else if (sub_q > REG_TOP) begin
							st_d = ST_IDLE;
						end else begin
							// Port configuration and DAC slot registers are locked.
							if (!(sub_q >= REG_PORT_LO && sub_q <= REG_PORT_HI)) begin
								regs_d[sub_q[3:0]] = dat;
							end
							sub_d = sub_q + 8'h01;
						end
					end
					default: st_d = ST_IDLE;
				endcase
			end
			// Frames of a read return bytes; start and stop frames return zero.
			if (hdr != HDR_IDLE) begin
				out_d = 8'h00;
			end
		end
		// Readback byte goes out at the bit offset past the sample word picked by the sense placement.
		tx_at = 6'(DATA_LSB) + {3'b000, regs_q[REG_SNS_POS[3:0]][2:0]};
		if (bit_q == tx_at) begin
			tx_d = out_q;
		end else if (bit_q > tx_at && bit_q <= tx_at + 6'h07) begin
			tx_d = {tx_q[6:0], 1'b0};
		end else if (bit_q == tx_at + 6'h08) begin
			// The line idles low outside the readback byte.
			tx_d = 8'h00;
		end
		if (!rst_s2_q) begin
			st_d = ST_IDLE;
			rd_d = 1'b0;
			sub_d = 8'h00;
			tog_d = 1'b0;
			out_d = 8'h00;
			tx_d = 8'h00;
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_d[i] = RESET_VALUE;
			end
		end
	end

	always_ff @(posedge link.bclk) begin
		bit_q <= bit_d;
		sh_q <= sh_d;
		tx_q <= tx_d;
		out_q <= out_d;
		st_q <= st_d;
		rd_q <= rd_d;
		sub_q <= sub_d;
		regs_q <= regs_d;
		smp_q <= smp_d;
		tog_q <= tog_d;
	end

	assign link.sdout = tx_q[7];

	// Samples cross to the system clock on a toggle; the word is stable for a frame.
	logic t1_q, t2_q, t3_q;
	logic [23:0] smp_o_d, smp_o_q;
	always_comb begin
		smp_o_d = (t2_q ^ t3_q) ? smp_q : smp_o_q;
		if (!i_rst_n) smp_o_d = 24'h000000;
	end
	always_ff @(posedge i_clk) begin
		t1_q <= tog_q;
		t2_q <= t1_q;
		t3_q <= t2_q;
		smp_o_q <= smp_o_d;
	end
	assign o_sample = smp_o_q;
	assign o_sample_stb = t2_q ^ t3_q;

	// Strap pins come from outside, so they pass two flops first.
	logic [3:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge i_clk) begin
		pin_s1_q <= {i_standalone, i_tdm_mode, i_ctl_pins};
		pin_s2_q <= pin_s1_q;
	end

	// Standalone forces fixed fields over the register view and uses the pins.
	always_comb begin
		o_regs_flat = regs_q;
		if (pin_s2_q[3]) begin
			for (int i = 0; i < REG_COUNT; i++) o_regs_flat[i] = RESET_VALUE;
			o_regs_flat[REG_POWER[3:0]][POWER_SOFT_POWER_DOWN_BIT] = 1'b0;
			o_regs_flat[REG_LIMIT[3:0]][LIMIT_EN_LSB +: 2] = 2'b00;
			o_regs_flat[REG_FORMAT[3:0]][FMT_AUTO_BIT] = 1'b1;
			o_regs_flat[REG_FORMAT[3:0]][FMT_SDATA_BIT] = 1'b0;
			o_regs_flat[REG_FORMAT[3:0]][FMT_PDM_BIT] = 1'b0;
			o_regs_flat[REG_TDM[3:0]][TDM_WIDTH_LSB +: 2] = TDM_WIDTH_64;
		end
	end
	assign o_sa_slot = (pin_s2_q[3] && pin_s2_q[2]) ? pin_s2_q[1:0] : 2'b00;
	assign o_boost_down = pin_s2_q[3] && !pin_s2_q[2] && pin_s2_q[0];
	assign o_shutdown = pin_s2_q[3] && !pin_s2_q[2] && pin_s2_q[1];
endmodule : tsc_device

// [design/tsc_host.sv]
`timescale 1ns/1ps
module tsc_host
	import tsc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	tsc_link_if.host link,
	input wire logic [7:0] i_hdr,
	input wire logic [7:0] i_data,
	input wire logic [23:0] i_sample,
	output logic o_frame_stb,
	output logic [7:0] o_rdata
);
	// Bit clock is i_clk divided by two; each group is 64 bit clocks.
	logic div_q, div_d;
	logic [5:0] bit_q, bit_d;
	logic [63:0] sh_q, sh_d;
	logic [7:0] rx_q, rx_d, rd_q, rd_d;
	// The host takes the readback byte at the device's reset placement.
	localparam logic [5:0] CAP_BIT = 6'(DATA_LSB + 7 + int'(RESET_VALUE[2:0]));
	always_comb begin
		// The divider keeps running through reset so the device can take
		// its reset on the bit clock; the branch starts it from a known level.
		if (div_q) begin
			div_d = 1'b0;
		end else begin
			div_d = 1'b1;
		end
		bit_d = bit_q;
		sh_d = sh_q;
		rx_d = rx_q;
		rd_d = rd_q;
		if (div_q) begin
			bit_d = bit_q + 6'h01;
			sh_d = {sh_q[62:0], 1'b0};
			rx_d = {rx_q[6:0], link.sdout};
			if (bit_q == 6'h3f) begin
				// Sample, header, data, blank every frame.
				sh_d = {i_sample, i_hdr, i_data, 24'h000000};
			end
			if (bit_q == CAP_BIT) begin
				rd_d = {rx_q[6:0], link.sdout};
			end
		end
		if (!i_rst_n) begin
			bit_d = 6'h3f;
			sh_d = '0;
			rx_d = 8'h00;
			rd_d = 8'h00;
		end
	end
	always_ff @(posedge i_clk) begin
		div_q <= div_d;
		bit_q <= bit_d;
		sh_q <= sh_d;
		rx_q <= rx_d;
		rd_q <= rd_d;
	end
	assign link.bclk = div_q;
	assign link.fsync = (bit_q == 6'h00);
	assign link.sdin = sh_q[63];
	assign o_frame_stb = div_q && bit_q == 6'h3f;
	assign o_rdata = rd_q;
endmodule : tsc_host

// [test/tsc_monitor.sv]
`timescale 1ns/1ps
module tsc_monitor (
	input wire logic i_rst_n,
	input wire logic bclk,
	input wire logic fsync,
	input wire logic sdin,
	input wire logic sdout
);
	logic [6:0] cnt_q, cnt_d, bit_ix;
	logic [7:0] sh_q, sh_d;
	logic run_q, run_d, rd_q, rd_d, rdf_q, rdf_d;
	// Own bit count and header decode, so the checks trust neither end.
	always_comb begin
		bit_ix = fsync ? 7'h00 : cnt_q;
		cnt_d = bit_ix + 7'h01;
		run_d = run_q | fsync;
		sh_d = {sh_q[6:0], sdin};
		rd_d = rd_q;
		if (bit_ix == 7'h20 && sh_q == 8'h05) rd_d = 1'b1;
		if (bit_ix == 7'h20 && sh_q == 8'h02) rd_d = 1'b0;
		rdf_d = (bit_ix == 7'h00) ? rd_q : rdf_q;
		if (!i_rst_n) begin
			run_d = 1'b0;
			rd_d = 1'b0;
			rdf_d = 1'b0;
		end
	end
	// Registers only.
	always_ff @(posedge bclk) begin
		{cnt_q, sh_q, run_q, rd_q, rdf_q} <= {cnt_d, sh_d, run_d, rd_d, rdf_d};
	end
	default clocking @(posedge bclk); endclocking
	default disable iff (!i_rst_n);
	fsync_pulse_a: assert property (fsync |=> !fsync)
		else $error("sync too wide");
	frame_len_a: assert property (run_q && fsync |-> cnt_q == 7'h40)
		else $error("frame not 64 bits");
	frame_next_a: assert property (run_q && bit_ix == 7'h3f |=> fsync)
		else $error("sync missing");
	hdr_pad_a: assert property (run_q && bit_ix inside {[7'h18:7'h1c]} |-> !sdin)
		else $error("header pad bit set");
	start_stop_a: assert property (run_q && bit_ix == 7'h1d && sdin |=> !sdin)
		else $error("start with stop");
	stop_rw_a: assert property (run_q && bit_ix == 7'h1e && sdin |=> !sdin)
		else $error("stop with read");
	read_start_a: assert property (run_q && bit_ix == 7'h1f && sdin |-> $past(sdin, 2))
		else $error("read without start");
	write_quiet_a: assert property (run_q && !rd_q && !rdf_q |-> !sdout)
		else $error("output outside read");
	cover property (run_q && rd_q && sdout);
	cover property (bit_ix == 7'h1d && sdin);
	cover property (rdf_q && !rd_q);
endmodule : tsc_monitor

// [test/tdm_slot_control_port_tb.sv]
`timescale 1ns/1ps
module tdm_slot_control_port_tb;
	import tsc_pkg::*;
	logic i_clk, i_rst_n, i_standalone, i_tdm_mode, o_frame_stb, boost, shut;
	logic [1:0] i_ctl_pins, sa_slot;
	logic [7:0] i_hdr, i_data, o_rdata, rd;
	logic [23:0] i_sample, o_sample, last;
	logic [7:0] regs [REG_COUNT];
	logic [7:0] r [3];
	int failures, cmp_count;
	tsc_link_if link();
	tsc_host u_tsc_host(.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link), .i_hdr(i_hdr),
		.i_data(i_data), .i_sample(i_sample), .o_frame_stb(o_frame_stb), .o_rdata(o_rdata));
	tsc_device u_tsc_device(.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link),
		.i_standalone(i_standalone), .i_tdm_mode(i_tdm_mode), .i_ctl_pins(i_ctl_pins),
		.o_sample(o_sample), .o_sample_stb(), .o_regs_flat(regs), .o_sa_slot(sa_slot),
		.o_boost_down(boost), .o_shutdown(shut));
	tsc_monitor u_tsc_monitor(.i_rst_n(i_rst_n), .bclk(link.bclk), .fsync(link.fsync),
		.sdin(link.sdin), .sdout(link.sdout));
	task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : check
	task automatic summarize();
		if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	// One frame: load the host, wait its strobe, then sample answers mid-frame.
	task automatic frame(input logic [7:0] h, input logic [7:0] d);
		int n;
		i_hdr = h;
		i_data = d;
		i_sample = {8'h5c, h, d};
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (o_frame_stb !== 1'b1 && n < 400);
		if (n >= 400) begin
			failures++;
			summarize();
		end
		repeat (64) @(posedge i_clk);
		#1;
		rd = o_rdata;
		if (!$isunknown(last)) check("sample", o_sample, last);
		last = i_sample;
	endtask : frame
	// Whole sequence plus a stray idle frame; keeps the three answer bytes.
	task automatic seq(input logic [7:0] h, s, a, b, c);
		frame(h, s);
		frame(HDR_IDLE, a);
		frame(HDR_IDLE, b);
		frame(HDR_IDLE, c);
		r[0] = rd;
		frame(HDR_STOP, 8'h00);
		r[1] = rd;
		frame(HDR_IDLE, 8'h99);
		r[2] = rd;
	endtask : seq
	task automatic wr_rd();
		seq(HDR_START_WR, 8'h06, 8'ha1, 8'ha2, 8'ha3);
		check("w6", regs[6], 8'ha1);
		check("w8", regs[8], 8'ha3);
		check("w9", regs[9], RESET_VALUE);
		check("wq", {r[0], r[1], r[2]}, 24'h0);
		seq(HDR_START_RD, 8'h06, 8'h00, 8'h00, 8'h00);
		check("rd", {r[0], r[1], r[2]}, 24'ha1a2a3);
	endtask : wr_rd
	task automatic locked_pos();
		seq(HDR_START_WR, REG_SNS_POS, 8'h09, 8'h5a, 8'h5b);
		check("w2", {regs[2], regs[3]}, {RESET_VALUE, RESET_VALUE});
		seq(HDR_START_RD, REG_SNS_POS, 8'h00, 8'h00, 8'h00);
		check("pos", {r[0], r[1], r[2]}, {8'h09, RESET_VALUE, RESET_VALUE});
	endtask : locked_pos
	task automatic top_edge();
		seq(HDR_START_WR, 8'h0e, 8'hb1, 8'hb2, 8'hb3);
		check("wtop", {regs[14], regs[15], regs[0]}, {16'hb1b2, RESET_VALUE});
		seq(HDR_START_RD, REG_TOP, 8'h00, 8'h00, 8'h00);
		check("rtop", {r[0], r[1], r[2]}, 24'hb2b2b2);
	endtask : top_edge
	task automatic standalone();
		i_standalone = 1'b1;
		i_tdm_mode = 1'b1;
		i_ctl_pins = 2'b10;
		repeat (16) @(posedge i_clk);
		#1;
		check("slot", sa_slot, 2'b10);
		check("pwr", regs[REG_POWER][0], 1'b0);
		check("fmt", regs[REG_FORMAT][2:0], 3'b001);
		check("tdm", {regs[REG_TDM][1:0], regs[REG_LIMIT][1:0]}, {TDM_WIDTH_64, 2'b00});
		i_tdm_mode = 1'b0;
		i_ctl_pins = 2'b11;
		repeat (16) @(posedge i_clk);
		#1;
		check("i2s", {boost, shut}, 2'b11);
	endtask : standalone
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// The device syncs reset into the slower bit clock, so it is held longer.
	initial begin
		{i_rst_n, i_standalone, i_tdm_mode, i_ctl_pins, i_hdr, i_data, i_sample} = '0;
		failures = 0;
		cmp_count = 0;
		last = 'x;
		repeat (8) @(posedge i_clk);
		#1 i_rst_n = 1'b1;
		frame(HDR_IDLE, 8'h00);
		wr_rd();
		locked_pos();
		top_edge();
		standalone();
		summarize();
	end
endmodule : tdm_slot_control_port_tb
